// *** hdl/fwd_defs.vh ***
`ifndef FWD_DEFS_VH
`define FWD_DEFS_VH
// Register offsets (word addresses on the plain register port)
`define REG_CTRL 4'h0
`define REG_PORT_STATE 4'h1
`define REG_PORT_CFG 4'h2
`define REG_MONITOR 4'h3
`define REG_TC_MAP 4'h4
`define REG_REGEN0 4'h5
`define REG_REGEN1 4'h6
`define REG_REGEN2 4'h7
`define REG_DS_WRITE 4'h8
`define REG_STATUS 4'h9
`define REG_COUNT 4'hA
// Control register field positions
`define CTRL_VLAN_EN 0
`define CTRL_MEMBER_CHECK 1
`define CTRL_ACCEPT_NONMEMBER 2
`define CTRL_DISCARD_UNLEARNED_UC 3
`define CTRL_BLOCK_UNLEARNED_MC 4
`define CTRL_DISCARD_YELLOW 5
`define CTRL_DISCARD_RED 6
`define CTRL_IGMP_MON 7
`define CTRL_MLD_MON 8
`define CTRL_DA_PRIO_EN 9
`define CTRL_IP_PREC_EN 10
`define CTRL_DS_EN 11
`define CTRL_VLAN_PRIO_EN 12
// Control register reset value
`define CTRL_RESET 13'h0000
// Spanning tree port state codes
`define STP_FORWARD 2'h0
`define STP_LEARN 2'h1
`define STP_BLOCK 2'h2
`define STP_DISABLED 2'h3
// Reset values
`define PORT_STATE_RESET 6'h00
`define PORT_CFG_RESET 3'h0
`define MONITOR_RESET 3'h1
`define TC_MAP_RESET 16'hFA50
`define REGEN_RESET 24'hFAC688
// Reserved VLAN identifier
`define VID_RESERVED 12'hFFF
// Verdict codes
`define VERDICT_FORWARD 2'h0
`define VERDICT_REDIRECT 2'h1
`define VERDICT_FILTER 2'h2
`define VERDICT_DISCARD 2'h3
`endif

// *** hdl/prio_regen.v ***
`timescale 1ns/1ps
// Per-port priority regeneration lookup, purely combinational
module prio_regen
#(
  parameter PORTS = 3
)
(
  input wire [PORTS*24-1:0] tables_i,
  input wire [1:0] port_i,
  input wire [2:0] tag_prio_i,
  output reg [2:0] regen_prio_o
);
  integer k;
  // Select the ingress port's table, then the entry for the tag priority
  always @*
  begin
    regen_prio_o = 3'h0;
    for (k = 0; k < PORTS; k = k + 1)
    begin
      if (port_i == k[1:0])
      begin
        regen_prio_o = tables_i[k*24 + tag_prio_i*3 +: 3];
      end
    end
  end
endmodule // prio_regen

// *** hdl/switch_forwarding.v ***
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "fwd_defs.vh"
// Contract
// - Destination equals source port: filter locally
// - Disabled source filters; learn/block unless override
// - Static plus age entry overrides port state
// - IGMP/MLD multicast redirected to monitor ports
// - Single disabled destination filters; else forwarding-only
// - Single learn/block destination filters unless override
// - Entry filter flag set: filter frame
// - Unlearned unicast/multicast filtered when enabled
// - Broadcast discarded at storm limit
// - Discard selected yellow, every red, when enabled
// - Flooded frames discarded above flood limit
// - Insufficient buffer space discards frame
// - Flooded frame with no forwarding destination filtered
// - Untagged frame filtered when tag required
// - Tagged VID FFF filtered
// - Nonmember ingress port filtered under membership check
// - Destinations limited to VLAN members
// - Flooded frame with empty VLAN domain filtered
// - Priority from five sources via class table
// - Port default priority from default VLAN entry
// - IP precedence from top three TOS bits
// - DS index from top six bits; host fills
// - Tag priority remapped by per-port regeneration table
module switch_forwarding
#(
  parameter PORTS = 3,
  parameter DS_ENTRIES = 64
)
(
  input wire clock_i,
  input wire reset_n_i,
  // Register port
  input wire [3:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_write_i,
  input wire reg_read_i,
  output reg [31:0] reg_rdata_o,
  // Frame decision request
  input wire frame_valid_i,
  input wire [1:0] src_port_i,
  input wire is_unicast_i,
  input wire is_multicast_i,
  input wire is_broadcast_i,
  input wire is_igmp_i,
  input wire is_mld_i,
  input wire no_lookup_i,
  input wire lookup_hit_i,
  input wire [PORTS-1:0] lookup_ports_i,
  input wire lookup_static_i,
  input wire lookup_age_i,
  input wire lookup_filter_i,
  input wire lookup_prio_en_i,
  input wire [2:0] lookup_prio_i,
  input wire storm_limit_i,
  input wire color_yellow_i,
  input wire yellow_selected_i,
  input wire color_red_i,
  input wire flood_limit_i,
  input wire buffer_short_i,
  input wire is_tagged_i,
  input wire [11:0] vid_i,
  input wire [2:0] tag_prio_i,
  input wire [PORTS-1:0] vlan_members_i,
  input wire [2:0] default_vid_prio_i,
  input wire is_ipv4_i,
  input wire is_ipv6_i,
  input wire [7:0] tos_i,
  // Decision answer
  output reg verdict_valid_o,
  output reg [1:0] verdict_o,
  output reg [PORTS-1:0] dest_ports_o,
  output reg [1:0] queue_o
);
  reg [12:0] ctrl_ff; // Global control bits
  reg [2*PORTS-1:0] port_state_ff; // Two state bits per port
  reg [PORTS-1:0] port_cfg_ff; // require_vlan_tag per port
  reg [PORTS-1:0] monitor_ff; // IGMP/MLD monitor destinations
  reg [15:0] tc_map_ff; // Two queue bits per priority
  reg [PORTS*24-1:0] regen_ff; // Regeneration tables, three bits per entry
  reg [2:0] ds_mem [0:DS_ENTRIES-1]; // Not reset: host must fill it
  reg [15:0] count_ff; // Decisions made, wraps
  reg [1:0] last_verdict_ff; // Most recent verdict for status read

  // Override only counts when an entry really matched the destination
  wire override = lookup_hit_i & lookup_static_i & lookup_age_i;
  // One-hot mask of the ingress port, removed from every destination set except the monitor set of a redirect
  wire [PORTS-1:0] src_bit = {{(PORTS-1){1'b0}}, 1'b1} << src_port_i;
  wire [1:0] src_state = port_state_ff[src_port_i*2 +: 2];
  wire single_hit;
  wire [PORTS-1:0] fwd_mask;
  wire [2:0] regen_prio;
  reg [1:0] dst_state;
  reg [PORTS-1:0] vlan_mask;
  reg [PORTS-1:0] dests;
  reg [PORTS-1:0] stp_dests; // Destinations left after port states only
  reg [1:0] verdict;
  reg [2:0] prio;
  reg member_src;
  integer i;
  genvar g;

  // Single destination when exactly one bit of the lookup port map is set
  assign single_hit = lookup_hit_i && (lookup_ports_i != {PORTS{1'b0}}) &&
    ((lookup_ports_i & (lookup_ports_i - 1'b1)) == {PORTS{1'b0}});

  // Ports in forwarding state, or any non-disabled port when overridden
  generate
    for (g = 0; g < PORTS; g = g + 1)
    begin : g_fwd
      assign fwd_mask[g] = (port_state_ff[g*2 +: 2] == `STP_FORWARD) ||
        (override && port_state_ff[g*2 +: 2] != `STP_DISABLED);
    end
  endgenerate

  // Regeneration table lookup for the ingress port
  prio_regen #(.PORTS(PORTS)) u_regen (
    .tables_i(regen_ff),
    .port_i(src_port_i),
    .tag_prio_i(tag_prio_i),
    .regen_prio_o(regen_prio)
  );

  // Forwarding decision; the first matching condition sets the verdict
  always @*
  begin
    dst_state = `STP_FORWARD;
    member_src = 1'b0;
    for (i = 0; i < PORTS; i = i + 1)
    begin
      if (lookup_ports_i[i])
      begin
        dst_state = port_state_ff[i*2 +: 2];
      end
      if (src_port_i == i[1:0])
      begin
        member_src = vlan_members_i[i];
      end
    end
    // Foreign VLAN arrives as empty membership, so containment covers it
    vlan_mask = (ctrl_ff[`CTRL_VLAN_EN] && ctrl_ff[`CTRL_MEMBER_CHECK]) ?
      vlan_members_i : {PORTS{1'b1}};
    // Never hand a frame back to its own ingress port, except a redirect to monitor_ff
    dests = (lookup_hit_i ? lookup_ports_i : {PORTS{1'b1}}) & ~src_bit;
    // Kept apart so an empty port-state result and an empty VLAN result differ
    stp_dests = dests & fwd_mask;
    if (!single_hit)
    begin
      dests = stp_dests & vlan_mask;
      if (ctrl_ff[`CTRL_VLAN_EN])
      begin
        dests = dests & vlan_members_i;
      end
    end
    verdict = `VERDICT_FORWARD;
    if (single_hit && lookup_ports_i[src_port_i])
    begin
      verdict = `VERDICT_FILTER;
    end
    else if (src_state == `STP_DISABLED)
    begin
      verdict = `VERDICT_FILTER;
    end
    else if (src_state != `STP_FORWARD && !override)
    begin
      verdict = `VERDICT_FILTER;
    end
    else if (is_multicast_i && !no_lookup_i &&
      ((is_igmp_i && ctrl_ff[`CTRL_IGMP_MON]) || (is_mld_i && ctrl_ff[`CTRL_MLD_MON])))
    begin
      verdict = `VERDICT_REDIRECT;
      dests = monitor_ff;
    end
    else if (single_hit && dst_state == `STP_DISABLED)
    begin
      verdict = `VERDICT_FILTER;
    end
    else if (single_hit && dst_state != `STP_FORWARD && !override)
    begin
      verdict = `VERDICT_FILTER;
    end
    else if (lookup_hit_i && lookup_filter_i)
    begin
      verdict = `VERDICT_FILTER;
    end
    else if (!lookup_hit_i && ((is_unicast_i && ctrl_ff[`CTRL_DISCARD_UNLEARNED_UC]) ||
      (is_multicast_i && ctrl_ff[`CTRL_BLOCK_UNLEARNED_MC])))
    begin
      verdict = `VERDICT_FILTER;
    end
    else if (is_broadcast_i && storm_limit_i)
    begin
      verdict = `VERDICT_DISCARD;
    end
    else if ((ctrl_ff[`CTRL_DISCARD_YELLOW] && color_yellow_i && yellow_selected_i) ||
      (ctrl_ff[`CTRL_DISCARD_RED] && color_red_i))
    begin
      verdict = `VERDICT_DISCARD;
    end
    else if (!lookup_hit_i && flood_limit_i)
    begin
      verdict = `VERDICT_DISCARD;
    end
    else if (buffer_short_i)
    begin
      verdict = `VERDICT_DISCARD;
    end
    else if (!single_hit && stp_dests == {PORTS{1'b0}})
    begin
      verdict = `VERDICT_FILTER;
    end
    else if (ctrl_ff[`CTRL_VLAN_EN] && !is_tagged_i && port_cfg_ff[src_port_i])
    begin
      verdict = `VERDICT_FILTER;
    end
    else if (ctrl_ff[`CTRL_VLAN_EN] && is_tagged_i && vid_i == `VID_RESERVED)
    begin
      verdict = `VERDICT_FILTER;
    end
    else if (ctrl_ff[`CTRL_VLAN_EN] && ctrl_ff[`CTRL_MEMBER_CHECK] &&
      !ctrl_ff[`CTRL_ACCEPT_NONMEMBER] && !member_src)
    begin
      verdict = `VERDICT_FILTER;
    end
    else if (single_hit && (lookup_ports_i & vlan_mask) == {PORTS{1'b0}})
    begin
      verdict = `VERDICT_FILTER;
    end
    else if (!single_hit && dests == {PORTS{1'b0}})
    begin
      verdict = `VERDICT_FILTER;
    end
    if (verdict == `VERDICT_FILTER || verdict == `VERDICT_DISCARD)
    begin
      dests = {PORTS{1'b0}};
    end
  end

  // Priority source selection; lookup value first, port default last
  always @*
  begin
    prio = default_vid_prio_i;
    if (ctrl_ff[`CTRL_DA_PRIO_EN] && lookup_hit_i && lookup_prio_en_i)
    begin
      prio = lookup_prio_i;
    end
    else if (ctrl_ff[`CTRL_DS_EN] && (is_ipv4_i || is_ipv6_i))
    begin
      prio = ds_mem[tos_i[7:2]];
    end
    else if (ctrl_ff[`CTRL_IP_PREC_EN] && is_ipv4_i)
    begin
      prio = tos_i[7:5];
    end
    else if (ctrl_ff[`CTRL_VLAN_PRIO_EN] && is_tagged_i)
    begin
      prio = regen_prio;
    end
  end

  // Verdict register: one answer per request, the cycle after it
  always @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      verdict_valid_o <= 1'b0;
      verdict_o <= `VERDICT_FORWARD;
      dest_ports_o <= {PORTS{1'b0}};
      queue_o <= 2'h0;
      count_ff <= 16'h0000;
      last_verdict_ff <= `VERDICT_FORWARD;
    end
    else
    begin
      verdict_valid_o <= frame_valid_i;
      if (frame_valid_i)
      begin
        verdict_o <= verdict;
        dest_ports_o <= dests;
        queue_o <= tc_map_ff[prio*2 +: 2];
        count_ff <= count_ff + 16'h0001;
        last_verdict_ff <= verdict;
      end
    end
  end

  // Register writes; the diffserv table has no reset by design
  always @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_ff <= `CTRL_RESET;
      port_state_ff <= `PORT_STATE_RESET;
      port_cfg_ff <= `PORT_CFG_RESET;
      monitor_ff <= `MONITOR_RESET;
      tc_map_ff <= `TC_MAP_RESET;
      regen_ff <= {`REGEN_RESET, `REGEN_RESET, `REGEN_RESET};
    end
    else if (reg_write_i)
    begin
      case (reg_addr_i)
        `REG_CTRL: ctrl_ff <= reg_wdata_i[12:0];
        `REG_PORT_STATE: port_state_ff <= reg_wdata_i[2*PORTS-1:0];
        `REG_PORT_CFG: port_cfg_ff <= reg_wdata_i[PORTS-1:0];
        `REG_MONITOR: monitor_ff <= reg_wdata_i[PORTS-1:0];
        `REG_TC_MAP: tc_map_ff <= reg_wdata_i[15:0];
        `REG_REGEN0: regen_ff[23:0] <= reg_wdata_i[23:0];
        `REG_REGEN1: regen_ff[47:24] <= reg_wdata_i[23:0];
        `REG_REGEN2: regen_ff[71:48] <= reg_wdata_i[23:0];
        default: ctrl_ff <= ctrl_ff; // Unmapped write ignored
      endcase
    end
  end

  // Diffserv entry write: index in bits 13:8, priority in bits 2:0
  always @(posedge clock_i)
  begin
    if (reg_write_i && reg_addr_i == `REG_DS_WRITE)
    begin
      ds_mem[reg_wdata_i[13:8]] <= reg_wdata_i[2:0];
    end
  end

  // Read data stands in the cycle after the strobe, zero otherwise
  always @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      reg_rdata_o <= 32'h00000000;
    end
    else
    begin
      reg_rdata_o <= 32'h00000000;
      if (reg_read_i)
      begin
        case (reg_addr_i)
          `REG_CTRL: reg_rdata_o <= {19'h0, ctrl_ff};
          `REG_PORT_STATE: reg_rdata_o <= {26'h0, port_state_ff};
          `REG_PORT_CFG: reg_rdata_o <= {29'h0, port_cfg_ff};
          `REG_MONITOR: reg_rdata_o <= {29'h0, monitor_ff};
          `REG_TC_MAP: reg_rdata_o <= {16'h0000, tc_map_ff};
          `REG_REGEN0: reg_rdata_o <= {8'h00, regen_ff[23:0]};
          `REG_REGEN1: reg_rdata_o <= {8'h00, regen_ff[47:24]};
          `REG_REGEN2: reg_rdata_o <= {8'h00, regen_ff[71:48]};
          `REG_STATUS: reg_rdata_o <= {30'h0, last_verdict_ff};
          `REG_COUNT: reg_rdata_o <= {16'h0000, count_ff};
          default: reg_rdata_o <= 32'h00000000; // Unmapped reads zero
        endcase
      end
    end
  end
endmodule // switch_forwarding

// *** testbench/ingress_src.sv ***
`timescale 1ns/1ps
// Ingress datapath stand-in: shows one frame's fields for one cycle
module ingress_src
(
  input wire clock_i,
  input wire send_i,
  input wire [56:0] fields_i,
  output reg valid_o = 1'b0,
  output reg [56:0] fields_o = 57'h0
);
  // Off-cycle fields turn to their inverse, so a stale value is never trusted
  always @(posedge clock_i)
  begin
    valid_o <= send_i;
    fields_o <= send_i ? fields_i : ~fields_o;
  end
endmodule // ingress_src

// *** testbench/fwd_check_sva.sv ***
`timescale 1ns/1ps
`include "fwd_defs.vh"
// Port-level checks on the forwarding verdict
module fwd_check_sva
#(
  parameter PORTS = 3
)
(
  input wire clock_i,
  input wire reset_n_i,
  input wire [3:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_write_i,
  input wire frame_valid_i,
  input wire [1:0] src_port_i,
  input wire is_broadcast_i,
  input wire lookup_hit_i,
  input wire [PORTS-1:0] lookup_ports_i,
  input wire storm_limit_i,
  input wire buffer_short_i,
  input wire verdict_valid_o,
  input wire [1:0] verdict_o,
  input wire [PORTS-1:0] dest_ports_o
);
  reg [5:0] state_ff; // Shadow of the port state word
  // Follow host writes so the source state check sees the live setting
  always @(posedge clock_i)
  begin
    if (!reset_n_i)
      state_ff <= `PORT_STATE_RESET;
    else if (reg_write_i && reg_addr_i == `REG_PORT_STATE)
      state_ff <= reg_wdata_i[5:0];
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  verdict_follow_a: assert property (frame_valid_i |=> verdict_valid_o)
    else $error("no verdict one cycle after frame");
  verdict_cause_a: assert property (verdict_valid_o |-> $past(frame_valid_i))
    else $error("verdict without frame");
  drop_empty_a: assert property (verdict_valid_o && verdict_o[1] |-> dest_ports_o == '0)
    else $error("dropped frame still has destinations");
  local_filter_a: assert property
    (frame_valid_i && lookup_hit_i && lookup_ports_i == (PORTS'(1) << src_port_i)
      |=> verdict_o == `VERDICT_FILTER)
    else $error("local traffic not filtered");
  no_echo_a: assert property
    (verdict_valid_o && verdict_o == `VERDICT_FORWARD |-> !dest_ports_o[$past(src_port_i)])
    else $error("frame forwarded back to its source");
  src_disabled_a: assert property
    (frame_valid_i && state_ff[2*src_port_i +: 2] == `STP_DISABLED
      |=> verdict_o == `VERDICT_FILTER)
    else $error("frame from disabled port not filtered");
  storm_drop_a: assert property
    (frame_valid_i && is_broadcast_i && storm_limit_i |=> verdict_o[1])
    else $error("broadcast passed at storm limit");
  short_drop_a: assert property
    (frame_valid_i && is_broadcast_i && buffer_short_i |=> verdict_o[1])
    else $error("frame passed without buffer space");
endmodule // fwd_check_sva

bind switch_forwarding fwd_check_sva #(.PORTS(PORTS)) chk_u (.clock_i(clock_i),
  .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_write_i(reg_write_i), .frame_valid_i(frame_valid_i), .src_port_i(src_port_i),
  .is_broadcast_i(is_broadcast_i), .lookup_hit_i(lookup_hit_i),
  .lookup_ports_i(lookup_ports_i), .storm_limit_i(storm_limit_i),
  .buffer_short_i(buffer_short_i), .verdict_valid_o(verdict_valid_o),
  .verdict_o(verdict_o), .dest_ports_o(dest_ports_o));

// *** testbench/switch_forwarding_and_queue_select_bench.sv ***
`timescale 1ns/1ps
`include "fwd_defs.vh"
// Self-checking bench for the forwarding decision
module switch_forwarding_and_queue_select_bench;
  typedef struct packed {
    logic [1:0] src; // Ingress port
    logic [2:0] cls; // Unicast, multicast, broadcast
    logic [2:0] lp; // Lookup ports, zero on a miss
    logic [2:0] mem; // VLAN members
    logic [11:0] fl; // Condition flags
    logic [5:0] ps; // Port state word
    logic [1:0] ev; // Expected verdict
    logic [2:0] ed; // Expected destinations
  } row_t;
  localparam U = 3'h4, M = 3'h2, B = 3'h1, FW = 2'h0, RD = 2'h1, FI = 2'h2, DI = 2'h3;
  localparam ST = 1, RE = 2, FD = 4, BS = 8, FT = 16, IG = 32, OV = 64, YE = 128;
  localparam MD = 256, NL = 512, UT = 1024, FF = 2048, P = 6'h10, Q = 6'h1C;
  // Port 2 learning throughout; Q also disables port 1
  row_t rows [0:25] = '{
    '{0, U, 2, 7, 0, P, FW, 2}, '{1, U, 2, 7, 0, P, FI, 0},
    '{2, U, 1, 7, 0, P, FI, 0}, '{2, U, 1, 7, OV, P, FW, 1},
    '{0, U, 4, 7, 0, P, FI, 0}, '{0, U, 4, 7, OV, P, FW, 4},
    '{0, M, 0, 7, 0, P, FW, 2}, '{1, M, 7, 7, 0, P, FW, 1},
    '{0, M, 5, 7, 0, P, FI, 0}, '{0, U, 0, 7, 0, P, FI, 0},
    '{1, M, 0, 7, IG, P, RD, 1}, '{1, M, 0, 7, MD, P, RD, 1},
    '{0, M, 2, 7, IG | NL, P, FW, 2}, '{0, U, 2, 7, FT, P, FI, 0},
    '{0, B, 0, 7, ST, P, DI, 0}, '{0, U, 2, 7, RE, P, DI, 0},
    '{0, U, 2, 7, YE, P, DI, 0}, '{0, B, 0, 7, FD, P, DI, 0},
    '{0, B, 0, 7, BS, P, DI, 0}, '{1, U, 1, 7, UT, P, FI, 0},
    '{0, U, 2, 7, FF, P, FI, 0}, '{0, U, 2, 6, 0, P, FI, 0},
    '{0, U, 2, 5, 0, P, FI, 0}, '{0, M, 0, 1, 0, P, FI, 0},
    '{1, U, 1, 7, OV, Q, FI, 0}, '{0, U, 2, 7, OV, Q, FI, 0}};
  logic [12:0] pb [4] = '{13'h1000, 13'h1400, 13'h1C00, 13'h1E00}; // Priority sources added
  logic [1:0] pq [4] = '{2'h0, 2'h2, 2'h1, 2'h0}; // Queue once each is added
  logic clock_i, reset_n_i = 1'b0, we = 1'b0, re = 1'b0, snd = 1'b0, fv, vv;
  logic [3:0] addr = 4'h0;
  logic [31:0] wd = 32'h0, rdata;
  logic [56:0] fields = 57'h0, f;
  logic [1:0] vd, qo;
  logic [2:0] dp;
  int n_fail = 0, n_checks = 0, n_frames = 0, cycles = 0;
  ingress_src ingress_u (.clock_i(clock_i), .send_i(snd), .fields_i(fields), .valid_o(fv),
    .fields_o(f));
  switch_forwarding dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_write_i(we), .reg_read_i(re), .reg_rdata_o(rdata),
    .frame_valid_i(fv), .src_port_i(f[56:55]), .is_unicast_i(f[54]), .is_multicast_i(f[53]),
    .is_broadcast_i(f[52]), .is_igmp_i(f[51]), .is_mld_i(f[50]), .no_lookup_i(f[49]),
    .lookup_hit_i(f[48]), .lookup_ports_i(f[47:45]), .lookup_static_i(f[44]),
    .lookup_age_i(f[43]), .lookup_filter_i(f[42]), .lookup_prio_en_i(f[41]),
    .lookup_prio_i(f[40:38]), .storm_limit_i(f[37]), .color_yellow_i(f[36]),
    .yellow_selected_i(f[35]), .color_red_i(f[34]), .flood_limit_i(f[33]),
    .buffer_short_i(f[32]), .is_tagged_i(f[31]), .vid_i(f[30:19]), .tag_prio_i(f[18:16]),
    .vlan_members_i(f[15:13]), .default_vid_prio_i(f[12:10]), .is_ipv4_i(f[9]),
    .is_ipv6_i(f[8]), .tos_i(f[7:0]), .verdict_valid_o(vv), .verdict_o(vd),
    .dest_ports_o(dp), .queue_o(qo));
  // Packs a row; priority inputs fixed: entry prio 0, tag prio 6, default 6, TOS A8
  function automatic logic [56:0] mk(input row_t r);
    logic [11:0] vid;
    vid = r.fl[10] ? 12'h000 : (r.fl[11] ? `VID_RESERVED : 12'h005);
    mk = {r.src, r.cls, r.fl[5], r.fl[8], r.fl[9], |r.lp, r.lp, r.fl[6], r.fl[6], r.fl[4], 4'h8,
      r.fl[0], r.fl[7], r.fl[7], r.fl[1], r.fl[2], r.fl[3], ~r.fl[10], vid, 3'h6, r.mem, 3'h6,
      2'h2, 8'hA8};
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clock_i);
    we <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clock_i);
    re <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask
  // Frame reaches the block one cycle after the request; verdict one cycle later
  task send(input row_t r);
    @(posedge clock_i);
    fields <= mk(r);
    snd <= 1'b1;
    @(posedge clock_i);
    snd <= 1'b0;
    @(posedge clock_i);
    #1;
    n_frames++;
    chk("valid", 1, vv);
  endtask
  task test_done;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // Run is a few hundred cycles; the ceiling leaves ample margin
  always @(posedge clock_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_fail++;
      test_done;
    end
  end
  initial
  begin
    repeat (8) @(posedge clock_i);
    reset_n_i <= 1'b1;
    #1;
    chk("reset out", 0, {vv, vd, dp, qo});
    rd(`REG_CTRL, `CTRL_RESET);
    rd(`REG_MONITOR, `MONITOR_RESET);
    rd(`REG_TC_MAP, `TC_MAP_RESET);
    for (int a = 5; a < 8; a++)
      rd(a, `REGEN_RESET);
    wr(4'hE, 32'hFFFF);
    rd(4'hE, 0);
    wr(`REG_CTRL, 32'h1EB);
    rd(`REG_CTRL, 32'h1EB);
    wr(`REG_PORT_CFG, 32'h2);
    $display("registers done");
    foreach (rows[i])
    begin
      wr(`REG_PORT_STATE, rows[i].ps);
      send(rows[i]);
      chk("verdict", rows[i].ev, vd);
      chk("dest", rows[i].ed, dp);
      if (rows[i].ev == FW)
        chk("queue", 3, qo);
      $display("row %0d done", i);
    end
    // Last row was filtered, so the status word must say so
    rd(`REG_STATUS, `VERDICT_FILTER);
    // Table must be whole before its source is enabled
    for (int k = 0; k < 64; k++)
      wr(`REG_DS_WRITE, (k << 8) | (k & 7));
    wr(`REG_REGEN0, 32'h053977);
    for (int k = 0; k < 4; k++)
    begin
      wr(`REG_CTRL, 32'h1EB | pb[k]);
      send(rows[0]);
      chk("queue", pq[k], qo);
    end
    rd(`REG_COUNT, n_frames);
    $display("priority done");
    // Nonmember source admitted once accept_nonmember is set
    wr(`REG_PORT_STATE, P);
    wr(`REG_CTRL, 32'h1EF);
    send(rows[21]);
    chk("verdict", FW, vd);
    chk("dest", 2, dp);
    $display("nonmember done");
    @(posedge clock_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    #1;
    chk("reset out", 0, {vv, vd, dp, qo});
    rd(`REG_CTRL, `CTRL_RESET);
    $display("reset done");
    test_done;
  end
endmodule // switch_forwarding_and_queue_select_bench
